// file: design/bala_core.sv
// byte alu datapath for add, and, shift and pointer-pair add operations
`timescale 1ns/100ps
`include "bala_params.svh"
module bala_core
    import bala_pkg::*;
#(
    parameter int DW = 8,
    parameter int PW = 16,
    parameter int AW = 7,
    parameter int LW = 6
) (
    // clock and reset
    input  wire logic           ref_clk,
    input  wire logic           sys_rst,
    // apb slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    // operation request from the decoder
    input  wire logic           op_valid,
    input  wire bala_op_e       op_code,
    input  wire logic [DW-1:0]  op_lit,
    input  wire logic           op_ptr_sel,
    input  wire logic [AW-1:0]  op_faddr,
    input  wire logic           op_dest,
    input  wire logic [DW-1:0]  f_rdata,
    output logic                op_ready,
    // file register write-back
    output logic                f_we,
    output logic      [AW-1:0]  f_waddr,
    output logic      [DW-1:0]  f_wdata,
    // visible state
    output logic      [DW-1:0]  w_out,
    output logic                carry_out,
    output logic                digit_carry_flag,
    output logic                zero_out,
    output logic      [PW-1:0]  ptr0_out,
    output logic      [PW-1:0]  ptr1_out
);

////////////////////////////////////////////////////////////////////////////
// state and helpers

logic [DW-1:0] w_reg;
logic [2:0]    flags_reg;
logic [PW-1:0] ptr0_reg;
logic [PW-1:0] ptr1_reg;
logic          f_we_reg;
logic [AW-1:0] f_waddr_reg;
logic [DW-1:0] f_wdata_reg;
bala_state_e   state_reg;
bala_state_e   state_next;

// sum with carry in; returns {carry, digit carry, sum}
function automatic logic [DW+1:0] add_bytes(
    input logic [DW-1:0] a,
    input logic [DW-1:0] b,
    input logic          cin
);
    logic [DW:0]            full;
    logic [`BALA_NIB_BITS:0] low;
    full = {1'b0, a} + {1'b0, b} + {{DW{1'b0}}, cin};
    low  = {1'b0, a[`BALA_NIB_BITS-1:0]} + {1'b0, b[`BALA_NIB_BITS-1:0]}
         + {{`BALA_NIB_BITS{1'b0}}, cin};
    return {full[DW], low[`BALA_NIB_BITS], full[DW-1:0]};
endfunction

////////////////////////////////////////////////////////////////////////////
// extra cycle for indirect window operands

logic file_op;
logic win_hit;
logic needs_extra;
logic exec;

// only register-form operations read a file operand
assign file_op = op_code inside {add_register_op, add_with_carry_op,
                                 and_register_op, arith_right_shift_op};
assign win_hit = ((op_faddr == `BALA_WIN0_ADDR) && ptr0_reg[PW-1]) ||
                 ((op_faddr == `BALA_WIN1_ADDR) && ptr1_reg[PW-1]);
assign needs_extra = op_valid && file_op && win_hit;
assign op_ready    = (state_reg == bala_extra) || !needs_extra;
assign exec        = op_valid && op_ready;

// one stall cycle, then the held request executes
always_comb begin
    state_next = state_reg;
    case (state_reg)
        bala_run:   state_next = needs_extra ? bala_extra : bala_run;
        bala_extra: state_next = op_valid ? bala_run : bala_extra;
        default:    state_next = bala_run;
    endcase
end

always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
        state_reg <= bala_run;
    end else begin
        state_reg <= state_next;
    end
end

////////////////////////////////////////////////////////////////////////////
// result and flag computation

logic [DW-1:0] res;
logic          res_c;
logic          res_dc;
logic          upd_c;
logic          upd_dc;
logic          upd_z;
logic          to_w;
logic          to_f;
logic [DW+1:0] sum;
logic [PW-1:0] lit_ext;
logic [PW-1:0] ptr_sum;

// sign-extend the 6-bit literal; 16-bit add drops the carry, so it wraps
assign lit_ext = {{(PW-LW){op_lit[`BALA_LIT_SIGN]}}, op_lit[LW-1:0]};
assign ptr_sum = (op_ptr_sel ? ptr1_reg : ptr0_reg) + lit_ext;

always_comb begin
    res    = `BALA_RST_BYTE;
    res_c  = 1'b0;
    res_dc = 1'b0;
    upd_c  = 1'b0;
    upd_dc = 1'b0;
    upd_z  = 1'b0;
    to_w   = 1'b0;
    to_f   = 1'b0;
    sum    = '0;
    case (op_code)
        add_literal_op: begin
            sum = add_bytes(w_reg, op_lit, 1'b0);
            to_w = 1'b1;
        end
        add_register_op: begin
            sum = add_bytes(w_reg, f_rdata, 1'b0);
            to_w = !op_dest;
            to_f = op_dest;
        end
        add_with_carry_op: begin
            sum = add_bytes(w_reg, f_rdata, flags_reg[`BALA_BIT_C]);
            to_w = !op_dest;
            to_f = op_dest;
        end
        and_literal_op: begin
            res   = w_reg & op_lit;
            upd_z = 1'b1;
            to_w  = 1'b1;
        end
        and_register_op: begin
            res   = w_reg & f_rdata;
            upd_z = 1'b1;
            to_w  = !op_dest;
            to_f  = op_dest;
        end
        arith_right_shift_op: begin
            res   = {f_rdata[DW-1], f_rdata[DW-1:1]};
            res_c = f_rdata[0];
            upd_c = 1'b1;
            upd_z = 1'b1;
            to_w  = !op_dest;
            to_f  = op_dest;
        end
        default: ;
    endcase
    // the three adds share one adder path and update all flags
    if ((op_code == add_literal_op) || (op_code == add_register_op) ||
        (op_code == add_with_carry_op)) begin
        res    = sum[DW-1:0];
        res_c  = sum[DW+1];
        res_dc = sum[DW];
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
    end
end

////////////////////////////////////////////////////////////////////////////
// apb decode

logic apb_wr;
logic apb_hit;

assign apb_wr  = psel && penable && pwrite;
assign apb_hit = (paddr == `BALA_OFS_WREG) || (paddr == `BALA_OFS_STATUS) ||
                 (paddr == `BALA_OFS_PTR0) || (paddr == `BALA_OFS_PTR1);
assign pready  = 1'b1;
assign pslverr = psel && penable && !apb_hit;

always_comb begin
    prdata = 32'h0000_0000;
    if (paddr == `BALA_OFS_WREG) begin
        prdata = {{(32-DW){1'b0}}, w_reg};
    end else if (paddr == `BALA_OFS_STATUS) begin
        prdata = {29'h0000_0000, flags_reg};
    end else if (paddr == `BALA_OFS_PTR0) begin
        prdata = {{(32-PW){1'b0}}, ptr0_reg};
    end else if (paddr == `BALA_OFS_PTR1) begin
        prdata = {{(32-PW){1'b0}}, ptr1_reg};
    end
end

////////////////////////////////////////////////////////////////////////////
// architectural registers; an executing operation beats a bus write

// working register
always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
        w_reg <= `BALA_RST_BYTE;
    end else if (exec && to_w) begin
        w_reg <= res;
    end else if (apb_wr && (paddr == `BALA_OFS_WREG)) begin
        w_reg <= pwdata[DW-1:0];
    end
end

// status flags, written by a bus write to the status offset, or each updated when its operation owns it
always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
        flags_reg <= `BALA_RST_FLAGS;
    end else begin
        if (apb_wr && (paddr == `BALA_OFS_STATUS)) begin
            flags_reg <= pwdata[2:0];
        end
        if (exec && upd_c) begin
            flags_reg[`BALA_BIT_C] <= res_c;
        end
        if (exec && upd_dc) begin
            flags_reg[`BALA_BIT_DC] <= res_dc;
        end
        if (exec && upd_z) begin
            flags_reg[`BALA_BIT_Z] <= (res == `BALA_RST_BYTE);
        end
    end
end

// pointer pairs; flags are not touched by this path
always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
        ptr0_reg <= `BALA_RST_PTR;
        ptr1_reg <= `BALA_RST_PTR;
    end else begin
        if (apb_wr && (paddr == `BALA_OFS_PTR0)) begin
            ptr0_reg <= pwdata[PW-1:0];
        end
        if (apb_wr && (paddr == `BALA_OFS_PTR1)) begin
            ptr1_reg <= pwdata[PW-1:0];
        end
        if (exec && (op_code == pointer_pair_add_op)) begin
            if (op_ptr_sel) begin
                ptr1_reg <= ptr_sum;
            end else begin
                ptr0_reg <= ptr_sum;
            end
        end
    end
end

// file write-back, registered so memory sees clean data a cycle later
always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
        f_we_reg    <= 1'b0;
        f_waddr_reg <= '0;
        f_wdata_reg <= `BALA_RST_BYTE;
    end else begin
        f_we_reg <= exec && to_f;
        if (exec && to_f) begin
            f_waddr_reg <= op_faddr;
            f_wdata_reg <= res;
        end
    end
end

assign f_we             = f_we_reg;
assign f_waddr          = f_waddr_reg;
assign f_wdata          = f_wdata_reg;
assign w_out            = w_reg;
assign carry_out        = flags_reg[`BALA_BIT_C];
assign digit_carry_flag = flags_reg[`BALA_BIT_DC];
assign zero_out         = flags_reg[`BALA_BIT_Z];
assign ptr0_out         = ptr0_reg;
assign ptr1_out         = ptr1_reg;

////////////////////////////////////////////////////////////////////////////
// checks

default clocking cb @(posedge ref_clk); endclocking
default disable iff (sys_rst);

chk_ptr_flags_kept: assert property (exec &&
    op_code == pointer_pair_add_op |=> $stable(flags_reg))
    else $error("pointer add changed flags");
chk_ptr_wrap_sum: assert property (exec && !op_ptr_sel &&
    op_code == pointer_pair_add_op |=> ptr0_reg == PW'($past(ptr0_reg) +
    {{(PW-LW){$past(op_lit[LW-1])}}, $past(op_lit[LW-1:0])}))
    else $error("pointer pair sum wrong");
chk_add_literal_op_w_sum: assert property (exec &&
    op_code == add_literal_op |=>
    w_reg == DW'($past(w_reg) + $past(op_lit)))
    else $error("add literal sum wrong");
chk_add_register_op_dest_f: assert property (exec && op_dest &&
    op_code == add_register_op |=> f_we && $stable(w_reg))
    else $error("add register misrouted");
chk_add_with_carry_op_carry: assert property (exec && op_dest &&
    op_code == add_with_carry_op |=> f_wdata == DW'($past(w_reg)
    + $past(f_rdata) + $past(flags_reg[`BALA_BIT_C])))
    else $error("add with carry sum wrong");
chk_and_literal_op_only_z: assert property (exec &&
    op_code == and_literal_op |=>
    $stable(flags_reg[1:0]) && w_reg == ($past(w_reg) & $past(op_lit)))
    else $error("and literal wrong");
chk_and_register_op_only_z: assert property (exec &&
    op_code == and_register_op |=> $stable(flags_reg[1:0]))
    else $error("and register touched carry");
chk_arith_right_shift_op_carry_out: assert property (exec &&
    op_code == arith_right_shift_op |=> carry_out == $past(f_rdata[0]))
    else $error("shift carry wrong");
chk_arith_right_shift_op_sign_kept: assert property (exec && !op_dest &&
    op_code == arith_right_shift_op |=> w_reg[DW-1] == $past(f_rdata[DW-1]))
    else $error("shift lost sign");
chk_window_stall: assert property (needs_extra &&
    state_reg == bala_run |-> !op_ready ##1 op_ready)
    else $error("window stall not one cycle");
chk_zero_flag: assert property (exec && upd_z |=>
    zero_out == ($past(to_f) ? (f_wdata == '0) : (w_reg == '0)))
    else $error("zero flag wrong");

cov_window_stall: cover property (needs_extra ##1 exec);
cov_carry_chain:  cover property (exec && op_code == add_with_carry_op
    && carry_out);
cov_ptr_wrap:     cover property (exec && op_code == pointer_pair_add_op
    && ptr0_reg == 16'hFFFF && !op_ptr_sel && op_lit[0]);

endmodule // bala_core

// file: design/bala_params.svh
// constants for the byte alu add and shift datapath
// Behaviour
// - pointer add sign-extends 6-bit literal onto selected 16-bit pair; flags untouched
// - pointer pair wraps modulo 2^16 past 0000h or FFFFh
// - add literal: W plus 8-bit literal into W, update C, DC, Z
// - add register: W plus file reg, dest bit picks W or file, C DC Z
// - add with carry: W plus file plus C, routed by dest, C DC Z
// - and literal: W AND literal into W, only Z changes
// - and register: W AND file, routed by dest, only Z changes
// - shift right: bits 7:1 to 6:0, bit 0 into C, update C, Z
// - shift keeps bit 7; result to W if dest 0, else file
// - window operand with pointer msb set costs one extra cycle
`ifndef BALA_PARAMS_SVH
`define BALA_PARAMS_SVH
`define BALA_OFS_WREG    12'h000
`define BALA_OFS_STATUS  12'h004
`define BALA_OFS_PTR0    12'h008
`define BALA_OFS_PTR1    12'h00C
`define BALA_BIT_C       0
`define BALA_BIT_DC      1
`define BALA_BIT_Z       2
`define BALA_RST_BYTE    8'h00
`define BALA_RST_PTR     16'h0000
`define BALA_RST_FLAGS   3'h0
`define BALA_WIN0_ADDR   7'h00
`define BALA_WIN1_ADDR   7'h01
`define BALA_LIT_SIGN    5
`define BALA_NIB_BITS    4
`endif

// file: design/bala_pkg.sv
// types shared by the byte alu add and shift datapath
package bala_pkg;
    typedef enum logic [2:0] {
        no_op,
        pointer_pair_add_op,
        add_literal_op,
        add_register_op,
        add_with_carry_op,
        and_literal_op,
        and_register_op,
        arith_right_shift_op
    } bala_op_e;
    typedef enum logic {
        bala_run,
        bala_extra
    } bala_state_e;
endpackage

// file: test/bala_mem_model.sv
// behavioural data memory standing on the far side of the datapath
`timescale 1ns/100ps
module bala_mem_model (
    // clock
    input  wire logic        ref_clk,
    // read side, driven by the decoder request
    input  wire logic        op_valid,
    input  wire logic [6:0]  op_faddr,
    output logic      [7:0]  f_rdata,
    // write-back side from the datapath
    input  wire logic        f_we,
    input  wire logic [6:0]  f_waddr,
    input  wire logic [7:0]  f_wdata
);
    logic [7:0] mem [128];

    // outside a request the read bus shows the inverse, never stale data
    assign f_rdata = op_valid ? mem[op_faddr] : ~mem[op_faddr];

    // write-back lands on the edge that sees the pulse
    always @(posedge ref_clk) begin
        if (f_we) begin
            mem[f_waddr] <= f_wdata;
        end
    end
endmodule // bala_mem_model

// file: test/byte_alu_add_and_shift_tb.sv
// self-checking bench for the byte alu datapath
`timescale 1ns/100ps
`include "bala_params.svh"
module byte_alu_add_and_shift_tb
    import bala_pkg::*;
;
    logic ref_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pready, pslverr, op_valid = 0, op_ptr_sel = 0, op_dest = 0;
    logic op_ready, f_we, carry_out, digit_carry_flag, zero_out, er;
    bala_op_e op_code = no_op;
    logic [7:0] op_lit = 0, f_rdata, f_wdata, w_out, ew;
    logic [6:0] op_faddr = 0, f_waddr;
    logic [15:0] ptr0_out, ptr1_out, ep0, ep1;
    logic ec, edc, ez;
    logic [7:0] em [128];
    int failures = 0, checked = 0, cycles = 0;

    bala_core bala_core_i (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code),
        .op_lit(op_lit), .op_ptr_sel(op_ptr_sel), .op_faddr(op_faddr),
        .op_dest(op_dest), .f_rdata(f_rdata), .op_ready(op_ready),
        .f_we(f_we), .f_waddr(f_waddr), .f_wdata(f_wdata),
        .w_out(w_out), .carry_out(carry_out),
        .digit_carry_flag(digit_carry_flag), .zero_out(zero_out),
        .ptr0_out(ptr0_out), .ptr1_out(ptr1_out));
    bala_mem_model bala_mem_model_i (.ref_clk(ref_clk), .op_valid(op_valid),
        .op_faddr(op_faddr), .f_rdata(f_rdata), .f_we(f_we),
        .f_waddr(f_waddr), .f_wdata(f_wdata));

    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard; 3000 cycles is far beyond the whole sequence
    initial forever #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // apb master: holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        // only the bench timeout ends a wait for the answer
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic chk_st();
        chk(32'({w_out, zero_out, digit_carry_flag, carry_out}),
            32'({ew, ez, edc, ec}));
        chk({ptr1_out, ptr0_out}, {ep1, ep0});
    endtask

    ////////////////////////////////////////////////////////////////////////
    // one operation: reference result first, then drive and compare
    task automatic do_op(input bala_op_e op, input logic [7:0] lit,
        input logic sel, input logic [6:0] fa, input logic d, input int st);
        logic [8:0] s;
        logic [7:0] b, r;
        logic ci, tofile;
        int n;
        b = (op == add_literal_op || op == and_literal_op) ? lit : em[fa];
        ci = (op == add_with_carry_op) ? ec : 1'b0;
        tofile = d && (op inside {add_register_op, add_with_carry_op,
                                  and_register_op, arith_right_shift_op});
        r = ew;
        case (op)
            pointer_pair_add_op: begin
                if (sel) ep1 = ep1 + {{10{lit[5]}}, lit[5:0]};
                else ep0 = ep0 + {{10{lit[5]}}, lit[5:0]};
            end
            add_literal_op, add_register_op, add_with_carry_op: begin
                s = {1'b0, ew} + {1'b0, b} + {8'h00, ci};
                edc = (int'(ew[3:0]) + int'(b[3:0]) + int'(ci)) > 15;
                r = s[7:0];
                ec = s[8];
            end
            and_literal_op, and_register_op: r = ew & b;
            arith_right_shift_op: begin
                r = {b[7], b[7:1]};
                ec = b[0];
            end
            default: ;
        endcase
        if (op != no_op && op != pointer_pair_add_op) begin
            ez = (r == 8'h00);
            if (tofile) em[fa] = r;
            else ew = r;
        end
        @(posedge ref_clk);
        op_valid <= 1;
        op_code <= op;
        op_lit <= lit;
        op_ptr_sel <= sel;
        op_faddr <= fa;
        op_dest <= d;
        n = 0;
        @(posedge ref_clk);
        while (op_ready !== 1'b1 && n < 8) begin
            n++;
            @(posedge ref_clk);
        end
        op_valid <= 0;
        chk(n, st);
        @(negedge ref_clk);
        chk(32'(f_we), 32'(tofile));
        if (tofile) chk(32'({f_waddr, f_wdata}), 32'({fa, r}));
        chk_st();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        ew = 0;
        ec = 0;
        edc = 0;
        ez = 0;
        ep0 = 0;
        ep1 = 0;
        for (int i = 0; i < 128; i++) begin
            em[i] = 8'(i) ^ 8'h5A;
            bala_mem_model_i.mem[i] = em[i];
        end
        em[5] = 8'h88;
        em[6] = 8'h81;
        em[7] = 8'h0F;
        bala_mem_model_i.mem[5] = 8'h88;
        bala_mem_model_i.mem[6] = 8'h81;
        bala_mem_model_i.mem[7] = 8'h0F;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 0;
        @(negedge ref_clk);
        chk_st();
        apb(1, `BALA_OFS_WREG, 32'h0000_000F);
        ew = 8'h0F;
        do_op(add_literal_op, 8'h01, 0, 0, 1, 0);
        do_op(add_literal_op, 8'hF0, 0, 0, 0, 0);
        do_op(add_with_carry_op, 8'h00, 0, 7, 0, 0);
        do_op(add_register_op, 8'h00, 0, 5, 1, 0);
        do_op(add_register_op, 8'h00, 0, 7, 0, 0);
        do_op(add_with_carry_op, 8'h00, 0, 5, 1, 0);
        do_op(and_literal_op, 8'hF0, 0, 0, 0, 0);
        do_op(and_literal_op, 8'h00, 0, 0, 0, 0);
        apb(1, `BALA_OFS_WREG, 32'h0000_00F3);
        ew = 8'hF3;
        do_op(and_register_op, 8'h00, 0, 5, 1, 0);
        do_op(and_register_op, 8'h00, 0, 7, 0, 0);
        do_op(arith_right_shift_op, 8'h00, 0, 6, 0, 0);
        do_op(arith_right_shift_op, 8'h00, 0, 7, 1, 0);
        do_op(no_op, 8'hFF, 0, 5, 1, 0);
        apb(1, `BALA_OFS_PTR0, 32'h0000_FFFF);
        ep0 = 16'hFFFF;
        do_op(pointer_pair_add_op, 8'hC1, 0, 0, 0, 0);
        do_op(pointer_pair_add_op, 8'h20, 1, 0, 0, 0);
        do_op(pointer_pair_add_op, 8'h1F, 1, 0, 0, 0);
        apb(1, `BALA_OFS_PTR0, 32'h0000_8000);
        ep0 = 16'h8000;
        do_op(add_register_op, 8'h00, 0, 0, 0, 1);
        do_op(arith_right_shift_op, 8'h00, 0, 1, 1, 1);
        do_op(add_with_carry_op, 8'h00, 0, 2, 0, 0);
        do_op(and_literal_op, 8'hFF, 0, 0, 0, 0);
        apb(0, `BALA_OFS_STATUS, 32'h0);
        chk(rd, 32'({ez, edc, ec}));
        apb(1, 12'h010, 32'h0000_0055);
        chk(32'(er), 32'h1);
        apb(0, 12'h010, 32'h0);
        chk(rd, 32'h0);
        apb(1, `BALA_OFS_STATUS, 32'h0000_0005);
        apb(0, `BALA_OFS_STATUS, 32'h0);
        chk(rd, 32'h0000_0005);
        apb(0, `BALA_OFS_WREG, 32'h0);
        chk(rd, 32'(ew));
        give_verdict();
    end
endmodule // byte_alu_add_and_shift_tb
